// ==== hw/apa_pkg.sv ====
package apa_pkg;
  // ==========================================================================
  // Time base
  // ==========================================================================
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_CYCLES = CLK_HZ;
  // ==========================================================================
  // Reversion timeout, in seconds
  // ==========================================================================
  localparam int unsigned REV_MIN_S = 240;
  localparam int unsigned REV_MAX_S = 480;
  localparam int unsigned REV_SPAN_S = REV_MAX_S - REV_MIN_S;
  localparam int unsigned SEC_W = 10;
  // ==========================================================================
  // Command fields
  // ==========================================================================
  localparam int unsigned IVL_W = 10;
  localparam logic [IVL_W-1:0] IVL_QUIET = 10'h000;
  localparam int unsigned STYPE_W = 4;
  localparam logic [STYPE_W-1:0] STYPE_ALL = 4'h0;
  localparam logic [STYPE_W-1:0] STYPE_INLAND = 4'h6;
  localparam int unsigned SCT_W = 8;
  localparam int unsigned MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
  localparam int unsigned LFSR_W = 16;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;

  typedef enum logic [1:0] {
    APA_AUTO = 2'b00,
    APA_GROUP = 2'b01,
    APA_DIRECT = 2'b10
  } apa_src_type;
endpackage : apa_pkg

// ==== hw/assignment_priority_arbiter.sv ====
// Behaviour
// - Addressed channel command mode beats group mode.
// - Group mode beats regional channel command mode.
// - Group mode reverts after random 240-480 s.
// - Manual interval ignored under group assignment.
// - Direct assignment outranks group and manual.
// - Group commands discarded during direct assignment.
// - Manual commands discarded during direct assignment.
// - Group longer interval or quiet keeps autonomous.
// - Manual longer interval or quiet keeps autonomous.
// - First transmission randomly within one interval.
// - Group accepted only inside its region.
// - Station type zero accepted, assigned mode.
// - Station type four declined.
// - Station type six accepted.
// - Later group command restarts reversion timeout.
// - Ship-cargo target must match own value.
// - Group timeout expiry resumes autonomous reporting.
`timescale 1ns/1ps
`default_nettype none
module assignment_priority_arbiter
  import apa_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Own configuration and autonomous schedule
  input wire logic [apa_pkg::IVL_W-1:0] autoInterval,
  input wire logic [apa_pkg::SCT_W-1:0] ownShipCargo,
  input wire logic [apa_pkg::MODE_W-1:0] ownTxRxMode,
  // Group assignment command, one-cycle strobe with fields
  input wire logic groupValid,
  input wire logic groupInRegion,
  input wire logic [apa_pkg::STYPE_W-1:0] groupStationType,
  input wire logic groupCargoUsed,
  input wire logic [apa_pkg::SCT_W-1:0] groupShipCargo,
  input wire logic [apa_pkg::IVL_W-1:0] groupInterval,
  input wire logic groupModeUsed,
  input wire logic [apa_pkg::MODE_W-1:0] groupTxRxMode,
  // Channel management command
  input wire logic chanValid,
  input wire logic chanAddressed,
  input wire logic chanRegionClear,
  input wire logic [apa_pkg::MODE_W-1:0] chanTxRxMode,
  // Directly addressed assignment
  input wire logic directValid,
  input wire logic [apa_pkg::IVL_W-1:0] directInterval,
  input wire logic directEnd,
  // Manual assignment from keypad or sentence
  input wire logic manualValid,
  input wire logic [apa_pkg::IVL_W-1:0] manualInterval,
  // Outputs
  output logic [apa_pkg::IVL_W-1:0] reportInterval,
  output logic [apa_pkg::MODE_W-1:0] txRxMode,
  output logic assignedMode,
  output logic [1:0] activeSource,
  output logic firstTxPulse,
  output logic secondTick
);
  import apa_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [31:0] tickCnt;
    logic tick;
    logic [LFSR_W-1:0] lfsr;
    apa_src_type src;
    logic [IVL_W-1:0] ivl;
    logic [SEC_W-1:0] revCnt;
    logic groupModeOn;
    logic chanAddrOn;
    logic chanRegOn;
    logic [MODE_W-1:0] chanMode;
    logic [MODE_W-1:0] grpMode;
    logic [SEC_W-1:0] modeCnt;
    logic firstPend;
    logic [IVL_W-1:0] firstCnt;
    logic firstPulse;
  } apa_state_type;

  apa_state_type st_reg;
  apa_state_type st_next;

  // Acceptance decisions for the strobes of the current cycle.
  logic regionOk;
  logic typeOk;
  logic cargoOk;
  logic groupOk;
  logic groupIvlOk;
  logic manualIvlOk;
  logic directTake;
  logic groupTake;
  logic groupModeTake;
  logic manualTake;
  logic [IVL_W-1:0] newIvl;
  logic [31:0] revDraw;
  logic [31:0] firstDraw;
  logic [SEC_W-1:0] randRev;
  logic [IVL_W-1:0] randFirst;
  logic tickWrap;
  logic revExpire;
  logic modeExpire;
  logic firstExpire;

  // ==========================================================================
  // Acceptance checks
  // ==========================================================================
  always_comb begin
    regionOk = groupInRegion;
    if (groupStationType == STYPE_ALL) begin
      typeOk = 1'b1;
    end else if (groupStationType == STYPE_INLAND) begin
      typeOk = 1'b1;
    end else begin
      // Every other station type selects some other class of station.
      typeOk = 1'b0;
    end
    if (groupCargoUsed) begin
      cargoOk = groupShipCargo == ownShipCargo;
    end else begin
      cargoOk = 1'b1;
    end
    groupOk = groupValid && regionOk && typeOk && cargoOk;
  end

  always_comb begin
    // A longer group or manual interval than autonomous never slows reporting down.
    if (groupInterval == IVL_QUIET) begin
      groupIvlOk = 1'b0;
    end else begin
      groupIvlOk = groupInterval <= autoInterval;
    end
    if (manualInterval == IVL_QUIET) begin
      manualIvlOk = 1'b0;
    end else begin
      manualIvlOk = manualInterval <= autoInterval;
    end
  end

  // ==========================================================================
  // Source priority
  // ==========================================================================
  always_comb begin
    directTake = directValid;
    groupTake = 1'b0;
    groupModeTake = 1'b0;
    manualTake = 1'b0;
    if (!directValid && st_reg.src != APA_DIRECT) begin
      if (groupOk) begin
        // The mode part of a group command is kept even when its interval
        // is refused as too long or quiet.
        groupModeTake = groupModeUsed;
        groupTake = groupIvlOk;
      end else begin
        manualTake = manualValid && st_reg.src == APA_AUTO &&
          manualIvlOk;
      end
    end
    if (directTake) begin
      newIvl = directInterval;
    end else if (groupTake) begin
      newIvl = groupInterval;
    end else begin
      newIvl = manualInterval;
    end
  end

  // ==========================================================================
  // Random draws
  // ==========================================================================
  always_comb begin
    // The LFSR draw is folded onto the span with a modulo; the slight bias
    // is accepted to avoid a rejection loop.
    revDraw = 32'(st_reg.lfsr) % (REV_SPAN_S + 1);
    randRev = SEC_W'(REV_MIN_S) + SEC_W'(revDraw);
    // The delay is drawn from the interval of the command being taken, not
    // from the registered one, so it never spans an older interval.
    firstDraw = 32'(st_reg.lfsr[LFSR_W-1:4]) % (32'(newIvl) + 32'h1);
    randFirst = IVL_W'(firstDraw);
  end

  // ==========================================================================
  // Time base and timer expiry
  // ==========================================================================
  always_comb begin
    tickWrap = st_reg.tickCnt == 32'(TICK_DIV - 1);
    revExpire = st_reg.tick && st_reg.src == APA_GROUP &&
      st_reg.revCnt <= SEC_W'(1);
    modeExpire = st_reg.tick && st_reg.groupModeOn &&
      st_reg.modeCnt <= SEC_W'(1);
    firstExpire = st_reg.tick && st_reg.firstPend &&
      st_reg.firstCnt == '0;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.firstPulse = 1'b0;

    // One-second tick.
    if (tickWrap) begin
      st_next.tickCnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tickCnt = st_reg.tickCnt + 32'h1;
    end

    // The LFSR steps every clock, so a draw depends on when a command lands.
    if (st_reg.lfsr[0]) begin
      st_next.lfsr = (st_reg.lfsr >> 1) ^ LFSR_TAPS;
    end else begin
      st_next.lfsr = st_reg.lfsr >> 1;
    end

    // Interval reversion timer.
    if (st_reg.tick && st_reg.src == APA_GROUP) begin
      if (revExpire) begin
        st_next.src = APA_AUTO;
        st_next.revCnt = '0;
      end else begin
        st_next.revCnt = st_reg.revCnt - SEC_W'(1);
      end
    end

    // Group Tx/Rx mode reversion timer.
    if (st_reg.tick && st_reg.groupModeOn) begin
      if (modeExpire) begin
        st_next.groupModeOn = 1'b0;
      end else begin
        st_next.modeCnt = st_reg.modeCnt - SEC_W'(1);
      end
    end

    // An addressed channel mode sticks; a regional one is withdrawn when
    // the own position has left its region.
    if (chanValid) begin
      if (chanAddressed) begin
        st_next.chanAddrOn = 1'b1;
        st_next.chanMode = chanTxRxMode;
      end else if (chanRegionClear) begin
        st_next.chanRegOn = 1'b0;
      end else begin
        st_next.chanRegOn = 1'b1;
        st_next.chanMode = chanTxRxMode;
      end
    end

    // A direct assignment ends only on its own end strobe.
    if (directEnd && st_reg.src == APA_DIRECT) begin
      st_next.src = APA_AUTO;
    end

    // Accepted commands, highest priority first.
    if (directTake) begin
      st_next.src = APA_DIRECT;
      st_next.ivl = directInterval;
      st_next.firstPend = 1'b1;
    end else begin
      if (groupModeTake) begin
        st_next.groupModeOn = 1'b1;
        st_next.grpMode = groupTxRxMode;
        st_next.modeCnt = randRev;
      end
      if (groupTake) begin
        st_next.src = APA_GROUP;
        st_next.ivl = groupInterval;
        st_next.revCnt = randRev;
        st_next.firstPend = 1'b1;
      end
      if (manualTake) begin
        st_next.ivl = manualInterval;
        st_next.firstPend = 1'b1;
      end
    end

    // First transmission delay. A command taken in the cycle in which an
    // older delay expires wins, so its own first transmission is not lost.
    if (directTake || groupTake || manualTake) begin
      st_next.firstCnt = randFirst;
    end else if (firstExpire) begin
      st_next.firstPend = 1'b0;
      st_next.firstPulse = 1'b1;
    end else if (st_reg.firstPend && st_reg.tick) begin
      st_next.firstCnt = st_reg.firstCnt - IVL_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{default: '0, lfsr: LFSR_SEED, src: APA_AUTO,
                 chanMode: MODE_RESET, grpMode: MODE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_comb begin
    if (st_reg.src == APA_AUTO && !st_reg.firstPend) begin
      reportInterval = autoInterval;
    end else begin
      reportInterval = st_reg.ivl;
    end
    if (st_reg.chanAddrOn) begin
      txRxMode = st_reg.chanMode;
    end else if (st_reg.groupModeOn) begin
      txRxMode = st_reg.grpMode;
    end else if (st_reg.chanRegOn) begin
      txRxMode = st_reg.chanMode;
    end else begin
      txRxMode = ownTxRxMode;
    end
    if (st_reg.src == APA_AUTO) begin
      assignedMode = 1'b0;
    end else begin
      assignedMode = 1'b1;
    end
    activeSource = st_reg.src;
    firstTxPulse = st_reg.firstPulse;
    secondTick = st_reg.tick;
  end
endmodule : assignment_priority_arbiter
`default_nettype wire

// ==== tb/apa_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module apa_monitor
  import apa_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Watched inputs
  input wire logic [apa_pkg::IVL_W-1:0] autoInterval,
  input wire logic groupValid,
  input wire logic groupInRegion,
  input wire logic [apa_pkg::STYPE_W-1:0] groupStationType,
  input wire logic groupCargoUsed,
  input wire logic [apa_pkg::IVL_W-1:0] groupInterval,
  input wire logic chanValid,
  input wire logic chanAddressed,
  input wire logic [apa_pkg::MODE_W-1:0] chanTxRxMode,
  input wire logic directValid,
  input wire logic directEnd,
  // Watched outputs
  input wire logic [apa_pkg::IVL_W-1:0] reportInterval,
  input wire logic [apa_pkg::MODE_W-1:0] txRxMode,
  input wire logic [1:0] activeSource
);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  logic grpOk;
  assign grpOk = groupValid && groupInRegion && !directValid &&
    activeSource != APA_DIRECT && !groupCargoUsed &&
    (groupStationType == STYPE_ALL || groupStationType == STYPE_INLAND);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_direct_wins: assert property (
    directValid |=> activeSource == APA_DIRECT) else $error("direct lost");
  a_direct_holds: assert property (
    activeSource == APA_DIRECT && !directEnd |=> activeSource == APA_DIRECT)
    else $error("direct dropped");
  a_direct_manual: assert property (
    activeSource == APA_DIRECT && !directValid && !directEnd
    |=> $stable(reportInterval)) else $error("interval moved in direct");
  a_region_out: assert property (
    groupValid && !groupInRegion && activeSource == APA_AUTO && !directValid
    |=> activeSource == APA_AUTO) else $error("outside region taken");
  a_type_four: assert property (
    groupValid && groupStationType == 4'h4 && activeSource == APA_AUTO &&
    !directValid |=> activeSource == APA_AUTO) else $error("type 4 taken");
  a_group_take: assert property (
    grpOk && groupInterval != IVL_QUIET && groupInterval <= autoInterval
    |=> activeSource == APA_GROUP && reportInterval == $past(groupInterval))
    else $error("group not applied");
  a_long_quiet: assert property (
    grpOk && activeSource == APA_AUTO &&
    (groupInterval == IVL_QUIET || groupInterval > autoInterval)
    |=> reportInterval == autoInterval) else $error("long interval used");
  a_addr_mode: assert property (
    chanValid && chanAddressed |=> txRxMode == $past(chanTxRxMode))
    else $error("addressed mode lost");
  c_group: cover property (grpOk);
  c_revert: cover property (activeSource == APA_GROUP ##1
    activeSource == APA_AUTO);
  c_addr: cover property (chanValid && chanAddressed);
endmodule : apa_monitor
bind assignment_priority_arbiter apa_monitor u_mon (.*);
`default_nettype wire

// ==== tb/apa_station.sv ====
`timescale 1ns/1ps
`default_nettype none
module apa_station (
  // Clock and request
  input wire logic mclk,
  input wire logic sendReq,
  input wire logic [26:0] cmdIn,
  // Command towards the station
  output logic groupValid,
  output logic [26:0] cmdOut
);
  // ==========================================================================
  // Fields are not held between commands; they flip every cycle instead.
  // ==========================================================================
  initial groupValid = 1'b0;
  initial cmdOut = '0;
  always @(negedge mclk) begin
    groupValid <= sendReq;
    cmdOut <= sendReq ? cmdIn : ~cmdOut;
  end
endmodule : apa_station
`default_nettype wire

// ==== tb/assignment_priority_arbiter_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module assignment_priority_arbiter_bench;
  import apa_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic mclk, resetn, sendReq, groupValid, ca, firstTx, tick, asg;
  logic [3:0] st;
  logic [26:0] cmdIn, cmd;
  logic [26:0] dec [3];
  logic [9:0] mi, di, ivl;
  logic [1:0] cmode, mode, src;
  int fails, checks, n;
  apa_station stn (.mclk(mclk), .sendReq(sendReq), .cmdIn(cmdIn),
    .groupValid(groupValid), .cmdOut(cmd));
  assignment_priority_arbiter #(.TICK_DIV(4)) uut (.mclk(mclk),
    .resetn(resetn), .autoInterval(10'h00A), .ownShipCargo(8'h21),
    .ownTxRxMode(2'h0), .groupValid(groupValid), .groupInRegion(cmd[26]),
    .groupStationType(cmd[25:22]), .groupCargoUsed(cmd[21]),
    .groupShipCargo(cmd[20:13]), .groupInterval(cmd[12:3]),
    .groupModeUsed(cmd[2]), .groupTxRxMode(cmd[1:0]), .chanValid(st[3]),
    .chanAddressed(ca), .chanRegionClear(1'b0), .chanTxRxMode(cmode),
    .directValid(st[2]), .directInterval(di), .directEnd(st[1]),
    .manualValid(st[0]), .manualInterval(mi), .reportInterval(ivl),
    .txRxMode(mode), .assignedMode(asg), .activeSource(src),
    .firstTxPulse(firstTx), .secondTick(tick));
  task test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task chk(input logic ok, input string m);
    checks++;
    if (!ok) begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  task grp(input logic [26:0] c);
    @(negedge mclk) sendReq <= 1'b1;
    cmdIn <= c;
    @(negedge mclk) sendReq <= 1'b0;
    @(negedge mclk);
  endtask : grp
  task fire(input logic [3:0] s);
    @(negedge mclk) st <= s;
    @(negedge mclk) st <= 4'h0;
    @(negedge mclk);
  endtask : fire
  // A timeout of 240 ticks is 960 cycles at four cycles a tick.
  task waitAuto(input int lo);
    n = 0;
    while (src !== APA_AUTO && n < 2100) begin
      @(negedge mclk);
      n++;
    end
    chk(n >= lo && src === APA_AUTO && asg === 1'b0, "reversion time");
  endtask : waitAuto
  function automatic logic [26:0] g(input logic r, input logic [3:0] t,
    input logic cu, input logic [9:0] v, input logic [1:0] md);
    return {r, t, cu, 8'h55, v, 1'b1, md};
  endfunction : g
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #400000;
    fails++;
    test_done;
  end
  initial begin
    resetn = 1'b0;
    sendReq = 1'b0;
    cmdIn = '0;
    st = 4'h0;
    di = 10'h005;
    ca = 1'b0;
    cmode = 2'h2;
    dec = '{g(0, 0, 0, 2, 0), g(1, 4, 0, 2, 0), g(1, 0, 1, 2, 0)};
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    n = 0;
    repeat (8) begin
      @(negedge mclk);
      n += tick;
    end
    chk(n == 2, "second tick");
    for (int i = 0; i < 2; i++) begin
      mi = (i == 0) ? 10'h014 : 10'h000;
      fire(4'h1);
      chk(ivl === 10'h00A, "manual long or quiet");
    end
    foreach (dec[i]) begin
      grp(dec[i]);
      chk(src === APA_AUTO && ivl === 10'h00A, "declined");
    end
    $display("test 1 done");
    grp(g(1, STYPE_ALL, 0, 10'h002, 2'h1));
    chk(src === APA_GROUP && ivl === 10'h002 && asg === 1'b1, "all");
    n = 0;
    while (firstTx !== 1'b1 && n < 16) begin
      @(negedge mclk);
      n++;
    end
    chk(firstTx === 1'b1, "first transmission");
    mi = 10'h003;
    fire(4'h1);
    chk(ivl === 10'h002 && src === APA_GROUP, "manual in group");
    waitAuto(900);
    $display("test 2 done");
    grp(g(1, STYPE_INLAND, 0, 10'h005, 2'h0));
    chk(src === APA_GROUP && ivl === 10'h005, "inland");
    repeat (800) @(negedge mclk);
    grp(g(1, STYPE_INLAND, 0, 10'h005, 2'h0));
    waitAuto(940);
    for (int i = 0; i < 2; i++) begin
      grp(g(1, 0, 0, (i == 0) ? 10'h014 : 10'h000, 2'h0));
      chk(ivl === 10'h00A, "group long or quiet");
    end
    $display("test 3 done");
    fire(4'h4);
    chk(src === APA_DIRECT && ivl === 10'h005, "direct");
    grp(g(1, 0, 0, 10'h002, 2'h0));
    chk(src === APA_DIRECT && ivl === 10'h005, "group in direct");
    mi = 10'h002;
    fire(4'h1);
    chk(src === APA_DIRECT && ivl === 10'h005, "manual in direct");
    fire(4'h2);
    chk(src !== APA_DIRECT, "direct end");
    $display("test 4 done");
    fire(4'h8);
    grp(g(1, 0, 0, 10'h002, 2'h1));
    chk(mode === 2'h1, "group over regional");
    ca = 1'b1;
    fire(4'h8);
    chk(mode === 2'h2, "addressed over group");
    $display("test 5 done");
    test_done;
  end
endmodule : assignment_priority_arbiter_bench
`default_nettype wire
